// ### include/meas_trig_pkg.sv
// Purpose: Shared constants and types for the measurement trigger control block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz clock
// Notes: Command codes and register offsets are defined here once
`default_nettype none
package meas_trig_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_RES = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OUTDATA = 8'h14;
  localparam logic [7:0] OFF_RANGES = 8'h18;

  // ==========================================================================
  // Command codes written to the command register
  localparam logic [3:0] CMD_CONF = 4'h1;
  localparam logic [3:0] CMD_QUERY_A = 4'h2;
  localparam logic [3:0] CMD_READ = 4'h3;
  localparam logic [3:0] CMD_INIT = 4'h4;
  localparam logic [3:0] CMD_FETCH = 4'h5;
  localparam logic [3:0] CMD_BUSTRIG = 4'h6;
  localparam logic [3:0] CMD_CLEAR = 4'h7;
  localparam logic [3:0] CMD_ROUTE = 4'h8;
  localparam logic [3:0] CMD_SETRANGE = 4'h9;

  // Range / resolution argument selectors
  localparam logic [1:0] ARG_VALUE = 2'h0;
  localparam logic [1:0] ARG_MIN = 2'h1;
  localparam logic [1:0] ARG_MAX = 2'h2;
  localparam logic [1:0] ARG_DEF = 2'h3;

  // Range codes
  localparam logic [2:0] RANGE_LOW = 3'h0;
  localparam logic [2:0] RANGE_HIGH = 3'h4;

  // Integration setting codes: 0.02, .2, 1, 2, 10, 20, 100, 200 line cycles
  localparam logic [2:0] ILC_0P02 = 3'h0;
  localparam logic [2:0] ILC_10 = 3'h4;
  localparam logic [2:0] ILC_200 = 3'h7;

  // Resolution divisors: resolution < range/DIV[i] selects setting i; the finest such i wins.
  // Thresholds 1e-4, 1e-5, 3e-6, 2.2e-6, 1e-6, 8e-7, 3e-7, 2.2e-7 of range,
  // held as parts per 100 million of range
  localparam int RES_SCALE = 100000000;
  localparam logic [31:0] THR_PPHM [8] = '{32'd10000, 32'd1000, 32'd300, 32'd220,
                                             32'd100, 32'd80, 32'd30, 32'd22};
  localparam logic [31:0] DEF_RES_PPHM = 32'd100;

  // Defaults after configure or query_a
  localparam logic TRIG_SRC_IMM = 1'b0;
  localparam logic TRIG_SRC_BUS = 1'b1;
  localparam logic [15:0] DEF_COUNT = 16'h0001;
  localparam logic DEF_CHANNEL = 1'b0;
  localparam logic DEF_FEED_STORE = 1'b1;
  localparam int MEM_DEPTH = 1024;

  // Status bit positions
  localparam int ST_WAIT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_MEMERR = 2;
  localparam int ST_OUTFULL = 3;
  localparam int ST_OUTVALID = 4;

  typedef enum {S_IDLE, S_WAIT, S_QUERY_A, S_FETCH} trig_state_t;

  typedef struct packed {
    logic [3:0] code;
    logic [1:0] rangeArg;
    logic [2:0] rangeVal;
    logic [1:0] resArg;
    logic channel;
    logic ratio;
  } cmd_t;

  typedef struct packed {
    logic [2:0] range;
    logic autoRange;
  } range_t;

endpackage
`default_nettype wire

// ### hdl/measurement_trigger_control.sv
// Purpose: Measurement sequencing and trigger control with AHB-Lite registers
// Assumes: Single clock; bus inputs synchronous to clk
// Notes: Reading data come from the converter port; output buffer is a small FIFO
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Any resolution maps to one of eight integration settings by range fractions.
// - Read-query moves trigger machine from idle to wait-for-trigger.
// - Read-query readings go to output buffer, never to internal memory.
// - Controller drains output buffer; measuring pauses while it is full.
// - Initiate enters wait-for-trigger and stores readings in up to 1024 entries.
// - Fetch copies stored readings from memory into output buffer.
// - Initiate with sample times trigger count above 1024 raises memory error.
// - After initiate, commands refused until done, except device clear, and bus trigger when source is bus.
// - Device clear aborts an initiate sequence.
// - In wait-for-trigger, measuring starts only when trigger condition is met.
// - Configure sets up only; trigger machine stays idle.
// - Query_a query presets, waits, self-triggers one reading into output buffer.
// - Query_a and configure reset parameters except function, range, resolution.
// - Range MIN lowest, MAX highest, AUTO or DEF autoranging. There is no AUTO selector; only ARG_DEF autoranges.
// - Resolution MIN finest, MAX coarsest, DEF one millionth of range, 10 cycles.
// - Voltage commands take channel one or two.
// - Integration setting shared by both channels, last configure wins.
// - Separate range per channel; route command switches active input.
// - In ratio mode channel 1 takes commanded range, channel 2 autoranges.
// - Feed disabled skips memory writes but statistics still accumulate.
// - Query_a query equals configure followed by read-query.
// - Defaults: channel 1, immediate trigger, auto delay, counts 1. No trigger delay is implemented.
module measurement_trigger_control #(
  parameter int OUT_DEPTH = 4,
  parameter int MEM_WORDS = meas_trig_pkg::MEM_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extTrig,
  input wire logic readingValid,
  input wire logic [31:0] readingData,
  output logic measureStart,
  output logic activeChannel,
  output logic [2:0] integrationLineCycles,
  output meas_trig_pkg::range_t activeRange
);
  import meas_trig_pkg::*;

  initial begin
    if (OUT_DEPTH < 2 || OUT_DEPTH > 256 || (OUT_DEPTH & (OUT_DEPTH - 1)) != 0 ||
        MEM_WORDS < 2 || MEM_WORDS > MEM_DEPTH) begin
      $error("measurement_trigger_control: unsupported parameter values");
    end
  end

  localparam int OW = $clog2(OUT_DEPTH);
  localparam int MW = $clog2(MEM_WORDS);

  // ==========================================================================
  // Bus slave: zero wait states, always OKAY
  logic dataPhase;
  logic dataWrite;
  logic [7:0] dataAddr;
  logic cmdStrobe;
  logic outPop;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr <= 8'h00;
    end else if (hready) begin
      dataPhase <= hsel && htrans[1];
      dataWrite <= hwrite;
      dataAddr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cmdStrobe = dataPhase && dataWrite && dataAddr == OFF_CMD;

  // ==========================================================================
  // Configuration state
  logic [31:0] resolution;
  logic [2:0] ilc;
  range_t chanRange [2];
  logic chanSel;
  logic trigSource;
  logic feedStore;
  logic ratioMode;
  logic [15:0] sampleCount;
  logic [15:0] trigCount;
  logic memError;
  trig_state_t state;
  cmd_t cmd;
  logic accepted;
  logic busy;

  assign cmd = cmd_t'(hwdata[12:0]);
  // Busy sequences refuse everything except clear, and bus trigger when source is bus
  assign accepted = cmdStrobe && (!busy || cmd.code == CMD_CLEAR ||
                    (cmd.code == CMD_BUSTRIG && trigSource == TRIG_SRC_BUS));

  // Maps resolution (parts per 1e8 of range) to integration setting
  function automatic logic [2:0] map_ilc(input logic [1:0] arg, input logic [31:0] res);
    logic [2:0] sel;
    sel = ILC_0P02;
    unique case (arg)
      ARG_MIN: sel = ILC_200;
      ARG_MAX: sel = ILC_0P02;
      ARG_DEF: sel = ILC_10;
      default: begin
        for (int i = 0; i < 8; i++) begin
          if (res < THR_PPHM[i]) begin
            sel = 3'(i);
          end
        end
      end
    endcase
    return sel;
  endfunction

  function automatic range_t map_range(input logic [1:0] arg, input logic [2:0] val);
    range_t r;
    r.autoRange = 1'b0;
    r.range = val;
    unique case (arg)
      ARG_MIN: r.range = RANGE_LOW;
      ARG_MAX: r.range = RANGE_HIGH;
      ARG_DEF: r.autoRange = 1'b1;
      default: r.range = val;
    endcase
    return r;
  endfunction

  logic isConfig;
  assign isConfig = accepted && (cmd.code == CMD_CONF || cmd.code == CMD_QUERY_A);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resolution <= DEF_RES_PPHM;
      ilc <= ILC_10;
      chanSel <= DEF_CHANNEL;
      ratioMode <= 1'b0;
      chanRange[0] <= '{range: RANGE_LOW, autoRange: 1'b1};
      chanRange[1] <= '{range: RANGE_LOW, autoRange: 1'b1};
    end else if (dataPhase && dataWrite && dataAddr == OFF_RES && !busy) begin
      resolution <= hwdata;
    end else if (isConfig) begin
      ilc <= map_ilc(cmd.resArg, resolution);
      chanSel <= cmd.ratio ? 1'b0 : cmd.channel;
      ratioMode <= cmd.ratio;
      if (cmd.ratio) begin
        chanRange[0] <= map_range(cmd.rangeArg, cmd.rangeVal);
        chanRange[1] <= '{range: RANGE_LOW, autoRange: 1'b1};
      end else begin
        chanRange[cmd.channel] <= map_range(cmd.rangeArg, cmd.rangeVal);
      end
    end else if (accepted && cmd.code == CMD_SETRANGE) begin
      chanRange[cmd.channel] <= map_range(cmd.rangeArg, cmd.rangeVal);
    end else if (accepted && cmd.code == CMD_ROUTE) begin
      chanSel <= cmd.channel;
    end
  end

  // Trigger/count settings, preset by configure and query_a
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigSource <= TRIG_SRC_IMM;
      feedStore <= DEF_FEED_STORE;
      sampleCount <= DEF_COUNT;
      trigCount <= DEF_COUNT;
    end else if (isConfig) begin
      trigSource <= TRIG_SRC_IMM;
      feedStore <= DEF_FEED_STORE;
      sampleCount <= DEF_COUNT;
      trigCount <= DEF_COUNT;
    end else if (dataPhase && dataWrite && !busy) begin
      if (dataAddr == OFF_CFG) begin
        trigSource <= hwdata[0];
        feedStore <= hwdata[1];
      end else if (dataAddr == OFF_COUNT) begin
        sampleCount <= hwdata[15:0];
        trigCount <= hwdata[31:16];
      end
    end
  end

  assign activeChannel = chanSel;
  assign activeRange = chanRange[chanSel];
  assign integrationLineCycles = ilc;

  // ==========================================================================
  // Trigger state machine and reading routing
  logic toMemory;
  logic [15:0] samplesLeft;
  logic [15:0] trigsLeft;
  logic [31:0] total;
  logic [MW:0] memCount;
  logic [MW:0] fetchIdx;
  logic [31:0] mem [MEM_WORDS];
  logic outFull;
  logic trigHit;
  logic pending;
  logic [31:0] statCount;
  logic lastReading;

  assign total = 32'(sampleCount) * 32'(trigCount);
  assign trigHit = trigSource == TRIG_SRC_BUS ?
                   (accepted && cmd.code == CMD_BUSTRIG) : (trigSource == TRIG_SRC_IMM);
  assign busy = state != S_IDLE && toMemory;
  assign lastReading = samplesLeft == 16'h0001 && trigsLeft == 16'h0001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      toMemory <= 1'b0;
      samplesLeft <= 16'h0000;
      trigsLeft <= 16'h0000;
      pending <= 1'b0;
      memError <= 1'b0;
      fetchIdx <= '0;
    end else if (accepted && cmd.code == CMD_CLEAR) begin
      state <= S_IDLE;
      pending <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (accepted && (cmd.code == CMD_READ || cmd.code == CMD_QUERY_A)) begin
            state <= S_WAIT;
            toMemory <= 1'b0;
            samplesLeft <= cmd.code == CMD_QUERY_A ? DEF_COUNT : sampleCount;
            trigsLeft <= cmd.code == CMD_QUERY_A ? DEF_COUNT : trigCount;
          end else if (accepted && cmd.code == CMD_INIT) begin
            if (total > 32'(MEM_WORDS)) begin
              memError <= 1'b1;
            end else begin
              state <= S_WAIT;
              toMemory <= 1'b1;
              samplesLeft <= sampleCount;
              trigsLeft <= trigCount;
            end
          end else if (accepted && cmd.code == CMD_FETCH) begin
            state <= S_FETCH;
            fetchIdx <= '0;
          end else if (accepted && cmd.code == CMD_CONF) begin
            memError <= 1'b0;
          end
        end
        S_WAIT: begin
          if (trigHit || (trigSource == TRIG_SRC_IMM)) begin
            state <= S_QUERY_A;
          end
        end
        S_QUERY_A: begin
          if (!pending && !(outFull && !toMemory)) begin
            pending <= 1'b1;
          end else if (pending && readingValid) begin
            pending <= 1'b0;
            if (lastReading) begin
              state <= S_IDLE;
            end else if (samplesLeft == 16'h0001) begin
              samplesLeft <= sampleCount;
              trigsLeft <= trigsLeft - 16'h0001;
              state <= S_WAIT;
            end else begin
              samplesLeft <= samplesLeft - 16'h0001;
            end
          end
        end
        S_FETCH: begin
          if (fetchIdx == memCount) begin
            state <= S_IDLE;
          end else if (!outFull) begin
            fetchIdx <= fetchIdx + 1'b1;
          end
        end
      endcase
    end
  end

  assign measureStart = state == S_QUERY_A && !pending && !(outFull && !toMemory);

  // Internal memory; storage may be disabled while statistics still count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memCount <= '0;
      statCount <= 32'h0000_0000;
    end else if (state == S_IDLE && accepted && cmd.code == CMD_INIT &&
                 total <= 32'(MEM_WORDS)) begin
      memCount <= '0;
      statCount <= 32'h0000_0000;
    end else if (state == S_QUERY_A && pending && readingValid && toMemory) begin
      statCount <= statCount + 32'h0000_0001;
      if (feedStore) begin
        memCount <= memCount + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (state == S_QUERY_A && pending && readingValid && toMemory && feedStore) begin
      mem[memCount[MW-1:0]] <= readingData;
    end
  end

  // ==========================================================================
  // Output buffer, first in first out
  logic [31:0] outBuf [OUT_DEPTH];
  logic [OW:0] wrPtr;
  logic [OW:0] rdPtr;
  logic outPush;
  logic [31:0] outIn;
  logic outEmpty;

  assign outPush = (state == S_QUERY_A && pending && readingValid && !toMemory) ||
                   (state == S_FETCH && fetchIdx != memCount && !outFull);
  assign outIn = state == S_FETCH ? mem[fetchIdx[MW-1:0]] : readingData;
  assign outEmpty = wrPtr == rdPtr;
  assign outFull = wrPtr[OW] != rdPtr[OW] && wrPtr[OW-1:0] == rdPtr[OW-1:0];
  assign outPop = dataPhase && !dataWrite && dataAddr == OFF_OUTDATA && !outEmpty;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (outPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (outPush) begin
      outBuf[wrPtr[OW-1:0]] <= outIn;
    end
  end

  // ==========================================================================
  // Read data mux
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dataPhase && !dataWrite) begin
      unique case (dataAddr)
        OFF_CFG: hrdata = {30'h0, feedStore, trigSource};
        OFF_RES: hrdata = resolution;
        OFF_COUNT: hrdata = {trigCount, sampleCount};
        OFF_STATUS: hrdata = {16'(statCount), 8'(memCount), 3'h0, !outEmpty, outFull,
                              memError, busy, state == S_WAIT};
        OFF_OUTDATA: hrdata = outEmpty ? 32'h0000_0000 : outBuf[rdPtr[OW-1:0]];
        OFF_RANGES: hrdata = {20'h0, 4'(ilc), chanRange[1], chanRange[0]};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  a_read_waits: assert property (@(posedge clk) disable iff (rst)
    (state == S_IDLE && accepted && cmd.code == CMD_READ) |=> state == S_WAIT)
    else $error("read-query did not enter wait state");
  a_no_mem_read: assert property (@(posedge clk) disable iff (rst)
    (state == S_QUERY_A && !toMemory) |-> !$changed(memCount) || $past(state) != S_QUERY_A)
    else $error("read-query reading reached memory");
  a_full_stalls: assert property (@(posedge clk) disable iff (rst)
    (outFull && !toMemory) |-> !measureStart && !outPush)
    else $error("measuring while output buffer full");
  a_mem_error: assert property (@(posedge clk) disable iff (rst)
    (state == S_IDLE && accepted && cmd.code == CMD_INIT && total > 32'(MEM_WORDS))
    |=> memError && state == S_IDLE)
    else $error("oversize initiate did not flag error");
  a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
    (busy && cmdStrobe && cmd.code == CMD_READ) |-> !accepted)
    else $error("command accepted during initiate sequence");
  a_clear_aborts: assert property (@(posedge clk) disable iff (rst)
    (accepted && cmd.code == CMD_CLEAR) |=> state == S_IDLE)
    else $error("clear did not abort sequence");
  a_conf_idle: assert property (@(posedge clk) disable iff (rst)
    (state == S_IDLE && accepted && cmd.code == CMD_CONF) |=> state == S_IDLE)
    else $error("configure left idle");
  a_conf_def: assert property (@(posedge clk) disable iff (rst)
    isConfig |=> sampleCount == DEF_COUNT && trigCount == DEF_COUNT && trigSource == TRIG_SRC_IMM)
    else $error("configure did not preset defaults");
  a_ratio_auto: assert property (@(posedge clk) disable iff (rst)
    (isConfig && cmd.ratio) |=> chanRange[1].autoRange && !chanSel)
    else $error("ratio did not autorange channel two");

endmodule
`default_nettype wire

// ### verif/converter_model.sv
// Purpose: Converter stand-in that answers reading requests
// Assumes: One reading in flight at a time
// Notes: Alternates a prompt and a slow answer; data line is inverted when idle
`timescale 1ns/10ps
`default_nettype none
module converter_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic measureStart,
  output logic readingValid,
  output logic [31:0] readingData
);
  logic [31:0] seq;
  logic [2:0] delay;
  logic busy;
  logic slow;
  // ==========================================================================
  // Request, delay and one-cycle answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq <= 32'h00000100;
      delay <= 3'h0;
      busy <= 1'b0;
      slow <= 1'b0;
      readingValid <= 1'b0;
      readingData <= 32'hffffffff;
    end else if (readingValid) begin
      readingValid <= 1'b0;
      readingData <= ~seq;
      seq <= seq + 32'h1;
    end else if (busy && delay == 3'h0) begin
      readingValid <= 1'b1;
      readingData <= seq;
      busy <= 1'b0;
    end else if (busy) begin
      delay <= delay - 3'h1;
    end else if (measureStart) begin
      busy <= 1'b1;
      delay <= slow ? 3'h4 : 3'h0;
      slow <= ~slow;
    end
  end
endmodule
`default_nettype wire

// ### verif/measurement_trigger_control_tb.sv
// Purpose: Self-checking bench for the measurement trigger control block
// Assumes: AHB-Lite master tasks, converter model on the reading port
// Notes: Output buffer depth 4, so a run of six readings fills it
`timescale 1ns/10ps
`default_nettype none
module measurement_trigger_control_tb;
  import meas_trig_pkg::*;
  localparam logic [1:0] ARGS [3] = '{ARG_MIN, ARG_MAX, ARG_DEF};
  localparam logic [3:0] RGX [3] = '{4'h0, 4'h8, 4'h1};
  localparam logic [2:0] ILCX [3] = '{3'h7, 3'h0, 3'h4};
  localparam logic [31:0] RESV [8] = '{32'd5000, 32'd500, 32'd250, 32'd150,
                                       32'd90, 32'd50, 32'd25, 32'd10};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, readingData, rd;
  logic hreadyout, hresp, measureStart, readingValid, activeChannel;
  logic [2:0] integrationLineCycles;
  range_t activeRange;
  logic [31:0] expNext = 32'h100;
  logic [15:0] base;
  int n_errors = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  measurement_trigger_control #(.OUT_DEPTH(4), .MEM_WORDS(MEM_DEPTH))
    measurement_trigger_control_inst (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .extTrig(1'b0),
    .readingValid(readingValid),
    .readingData(readingData),
    .measureStart(measureStart),
    .activeChannel(activeChannel),
    .integrationLineCycles(integrationLineCycles),
    .activeRange(activeRange)
  );
  converter_model converter_model_inst (
    .clk(clk),
    .rst(rst),
    .measureStart(measureStart),
    .readingValid(readingValid),
    .readingData(readingData)
  );
  // ==========================================================================
  // Tasks
  task close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task waitReady();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task stbit(input int b, input logic v);
    int i;
    i = 0;
    do begin
      xfer(1'b0, OFF_STATUS, 32'h0);
      i++;
    end while (rd[b] !== v && i < 100);
    chk("status bit", {31'h0, v}, {31'h0, rd[b]});
    if (rd[b] !== v) begin
      close_out();
    end
  endtask
  task pops(input int n);
    repeat (n) begin
      stbit(ST_OUTVALID, 1'b1);
      rdchk("reading", OFF_OUTDATA, expNext);
      expNext++;
    end
  endtask
  function logic [31:0] cmd(input logic [3:0] c, input logic [1:0] ra, input logic [1:0] sa);
    return {19'h0, c, ra, 3'h0, sa, 2'h0};
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("ranges", OFF_RANGES, 32'h00000411);
    chk("channel", 32'h0, {31'h0, activeChannel});
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, OFF_CMD, cmd(CMD_CONF, ARGS[k], ARGS[k]));
      rdchk("arg ranges", OFF_RANGES, {20'h0, 1'b0, ILCX[k], 4'h1, RGX[k]});
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("conf wait", 32'h0, {31'h0, rd[ST_WAIT]});
    end
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, OFF_RES, RESV[k]);
      xfer(1'b1, OFF_CMD, cmd(CMD_CONF, ARG_MAX, ARG_VALUE));
      @(posedge clk);
      chk("ilc", {29'h0, 3'(k)}, {29'h0, integrationLineCycles});
    end
    // Ratio forces channel one and autoranges channel two; then route to two
    xfer(1'b1, OFF_CMD, cmd(CMD_CONF, ARG_MAX, ARG_DEF) | 32'h3);
    rdchk("ratio ranges", OFF_RANGES, 32'h00000418);
    chk("ratio channel", 32'h0, {31'h0, activeChannel});
    xfer(1'b1, OFF_CMD, cmd(CMD_SETRANGE, ARG_MIN, ARG_VALUE) | 32'h2);
    xfer(1'b1, OFF_CMD, cmd(CMD_ROUTE, 2'h0, 2'h0) | 32'h2);
    rdchk("chan ranges", OFF_RANGES, 32'h00000408);
    chk("routed channel", 32'h1, {31'h0, activeChannel});
    chk("routed range", 32'h0, {28'h0, activeRange});
    // Six readings through a four-deep buffer
    xfer(1'b1, OFF_CMD, cmd(CMD_CONF, ARG_DEF, ARG_DEF));
    xfer(1'b1, OFF_COUNT, {16'h1, 16'h6});
    xfer(1'b1, OFF_CMD, cmd(CMD_READ, 2'h0, 2'h0));
    stbit(ST_OUTFULL, 1'b1);
    repeat (30) @(posedge clk);
    chk("paused", 32'h0, {31'h0, measureStart});
    pops(6);
    rdchk("mem after read", OFF_STATUS, {16'h0, 8'h0, 8'h00});
    // Query_a query presets counts to one
    xfer(1'b1, OFF_COUNT, {16'h1, 16'h3});
    xfer(1'b1, OFF_CMD, cmd(CMD_QUERY_A, ARG_DEF, ARG_DEF));
    pops(1);
    repeat (40) @(posedge clk);
    stbit(ST_OUTVALID, 1'b0);
    // Bus trigger in read mode
    xfer(1'b1, OFF_CFG, 32'h3);
    xfer(1'b1, OFF_CMD, cmd(CMD_READ, 2'h0, 2'h0));
    stbit(ST_WAIT, 1'b1);
    repeat (20) @(posedge clk);
    chk("no trigger", 32'h0, {31'h0, measureStart});
    xfer(1'b1, OFF_CMD, cmd(CMD_BUSTRIG, 2'h0, 2'h0));
    pops(1);
    // Initiate, refusals, bus trigger, fetch
    xfer(1'b1, OFF_COUNT, {16'h1, 16'h2});
    xfer(1'b1, OFF_CMD, cmd(CMD_INIT, 2'h0, 2'h0));
    stbit(ST_BUSY, 1'b1);
    xfer(1'b1, OFF_COUNT, {16'h1, 16'h1});
    xfer(1'b1, OFF_CMD, cmd(CMD_CONF, ARG_DEF, ARG_DEF));
    rdchk("count kept", OFF_COUNT, {16'h1, 16'h2});
    stbit(ST_WAIT, 1'b1);
    xfer(1'b1, OFF_CMD, cmd(CMD_BUSTRIG, 2'h0, 2'h0));
    stbit(ST_BUSY, 1'b0);
    chk("mem count", 32'h2, {24'h0, rd[15:8]});
    chk("out empty", 32'h0, {31'h0, rd[ST_OUTVALID]});
    xfer(1'b1, OFF_CMD, cmd(CMD_FETCH, 2'h0, 2'h0));
    pops(2);
    xfer(1'b1, OFF_CMD, cmd(CMD_INIT, 2'h0, 2'h0));
    stbit(ST_BUSY, 1'b1);
    xfer(1'b1, OFF_CMD, cmd(CMD_CLEAR, 2'h0, 2'h0));
    stbit(ST_BUSY, 1'b0);
    // Storage off: statistics only
    xfer(1'b1, OFF_CFG, 32'h0);
    xfer(1'b0, OFF_STATUS, 32'h0);
    base = rd[31:16];
    xfer(1'b1, OFF_CMD, cmd(CMD_INIT, 2'h0, 2'h0));
    stbit(ST_BUSY, 1'b0);
    chk("no store", 32'h0, {24'h0, rd[15:8]});
    chk("stats", {16'h0, base + 16'h2}, {16'h0, rd[31:16]});
    // Oversized sequence
    xfer(1'b1, OFF_COUNT, {16'd32, 16'd33});
    xfer(1'b1, OFF_CMD, cmd(CMD_INIT, 2'h0, 2'h0));
    stbit(ST_MEMERR, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
